// >>> logic/mpcd_top.sv
// Purpose: configuration and phase generation of a multiphase clock buffer
// Assumes: clk stands for the oscillator running at N times nominal frequency
// Notes:   all select pins but the reference select are static straps sampled through two flops
//
// Operation
// - The loop moves the phase generator until feedback rises with the chosen reference.
// - After a reference switch the loop only retards, so no output period shortens.
// - The skew unit is one oscillator period, with N of 32, 16 or 8 for low, mid, high.
// - Bank one, bank two and the feedback output each take their own divide selects.
// - Bank one outputs 0-1, bank one outputs 2-3 and bank two each take a phase pair.
// - A bank one pair maps its nine codes to skews of -4 through +4 units.
// - The bank two pair gives -8,-7,-6, group A, 0, group B, +6,+7,+8 units.
// - The feedback phase select gives only -4, 0 or +4 units.
// - Every divide pair maps its nine codes to 1,2,3,4,5,6,8,10,12.
// - A skewed feedback output shifts all other outputs the opposite way.
// - Reference select low takes the primary reference, high the secondary, default low.
// - An open three-level select reads as mid; changing it may glitch outputs.
`timescale 1ns/10ps
module mpcd_top
  import mpcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] freqRangeSelect,
  input  wire logic       refSourceSelect,
  input  wire logic       primaryReference,
  input  wire logic       secondaryReference,
  input  wire logic       feedbackInput,
  input  wire logic [7:0] bank1PhaseSelect,
  input  wire logic [3:0] bank2PhaseSelect,
  input  wire logic [1:0] feedbackPhaseSelect,
  input  wire logic [3:0] bank1DivideSelect,
  input  wire logic [3:0] bank2DivideSelect,
  input  wire logic [3:0] feedbackDivideSelect,
  output logic      [3:0] bank1Outputs,
  output logic      [5:0] bank2Outputs,
  output logic            feedbackClockOut,
  output logic            reacquiring
);

  localparam int NUM_OUT = 11;

  logic [31:0]        pinRaw;
  logic [31:0]        pinMeta_ff;
  logic [31:0]        pinSync_ff;
  logic [1:0]         rangeSel;
  logic               ref_source_select;
  logic               primary_reference;
  logic               secondary_reference;
  logic               fbIn;
  logic [7:0]         b1Ph;
  logic [3:0]         b2Ph;
  logic [1:0]         fbPh;
  logic [3:0]         b1Div;
  logic [3:0]         b2Div;
  logic [3:0]         fbDiv;
  logic [1:0]         rangeLvl;
  logic [5:0]         nFactor;
  logic [3:0]         idxA;
  logic [3:0]         idxB;
  logic [3:0]         idx2;
  logic [3:0]         b1DivIdx;
  logic signed [4:0]  skewA;
  logic signed [4:0]  skewB;
  logic signed [4:0]  skew2;
  logic signed [4:0]  fbSkew;
  logic [11:0]        pB1;
  logic [11:0]        pB2;
  logic [11:0]        pFb;
  logic [11:0]        frameLimit;
  logic [11:0]        frame_ff;
  logic [12:0]        frameSum;
  logic               frameWrap;
  logic               frameExcess;
  logic               refPick;
  logic               refPrev_ff;
  logic               fbPrev_ff;
  logic               refSelPrev_ff;
  logic               refRise;
  logic               fbRise;
  logic [11:0]        sinceRef_ff;
  logic [11:0]        refPeriod_ff;
  logic               fbLags;
  logic [1:0]         step_ff;
  logic [1:0]         nxt_step;
  mpcd_loop_type      loopState_ff;
  mpcd_loop_type      nxt_loopState;
  logic [NUM_OUT-1:0] chanClk;

  // every strap and clock pin is asynchronous to clk
  assign pinRaw = {freqRangeSelect, refSourceSelect, primaryReference, secondaryReference,
                   feedbackInput, bank1PhaseSelect, bank2PhaseSelect, feedbackPhaseSelect,
                   bank1DivideSelect, bank2DivideSelect, feedbackDivideSelect};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinMeta_ff <= PIN_RESET;
      pinSync_ff <= PIN_RESET;
    end else begin
      pinMeta_ff <= pinRaw;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // a zero reset value keeps the reference select low until the pin is seen
  assign {rangeSel, ref_source_select, primary_reference, secondary_reference, fbIn, b1Ph, b2Ph, fbPh,
          b1Div, b2Div, fbDiv} = pinSync_ff;

  // the board must strap the range to the undivided output frequency
  assign rangeLvl = mpcd_tri_level(rangeSel);

  always_comb begin
    if (rangeLvl == TRI_LOW) begin
      nFactor = N_LOW;
    end else if (rangeLvl == TRI_HIGH) begin
      nFactor = N_HIGH;
    end else begin
      nFactor = N_MID;
    end
  end

  // phase groups: bank one 0-1, bank one 2-3, bank two
  assign idxA = mpcd_sel_index(b1Ph[3:2], b1Ph[1:0]);
  assign idxB = mpcd_sel_index(b1Ph[7:6], b1Ph[5:4]);
  assign idx2 = mpcd_sel_index(b2Ph[3:2], b2Ph[1:0]);

  assign skewA = $signed({1'b0, idxA}) - B1_SKEW_BIAS;
  assign skewB = $signed({1'b0, idxB}) - B1_SKEW_BIAS;

  always_comb begin
    if (idx2 <= B2_LOW_LAST) begin
      skew2 = $signed({1'b0, idx2}) - B2_SKEW_BIAS;
    end else if (idx2 == B2_FOLLOW_A) begin
      skew2 = skewA;
    end else if (idx2 == SEL_CENTER) begin
      skew2 = SKEW_ZERO;
    end else if (idx2 == B2_FOLLOW_B) begin
      skew2 = skewB;
    end else begin
      skew2 = $signed({1'b0, idx2});
    end
  end

  always_comb begin
    if (mpcd_tri_level(fbPh) == TRI_LOW) begin
      fbSkew = -FB_SKEW_STEP;
    end else if (mpcd_tri_level(fbPh) == TRI_HIGH) begin
      fbSkew = FB_SKEW_STEP;
    end else begin
      fbSkew = SKEW_ZERO;
    end
  end

  assign b1DivIdx = mpcd_sel_index(b1Div[3:2], b1Div[1:0]);
  assign pB1      = mpcd_period(nFactor, DIV_TABLE[b1DivIdx]);
  assign pB2      = mpcd_period(nFactor, DIV_TABLE[mpcd_sel_index(b2Div[3:2], b2Div[1:0])]);
  assign pFb      = mpcd_period(nFactor, DIV_TABLE[mpcd_sel_index(fbDiv[3:2], fbDiv[1:0])]);

  // frame counter shared by all outputs; holds and slips move every output together
  assign frameLimit  = {6'h00, nFactor} * {5'h00, FRAME_PERIODS};
  assign frameSum    = {1'b0, frame_ff} + {11'h000, step_ff};
  assign frameWrap   = frameSum >= {1'b0, frameLimit};
  assign frameExcess = frameWrap && (frameSum == {1'b0, frameLimit} + 13'h0001);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_ff <= 12'h000;
    end else if (frameWrap) begin
      frame_ff <= {11'h000, frameExcess};
    end else begin
      frame_ff <= frameSum[11:0];
    end
  end

  // phase detector on the chosen reference and the returned feedback clock
  assign refPick = ref_source_select ? secondary_reference : primary_reference;
  assign refRise = refPick && !refPrev_ff;
  assign fbRise  = fbIn && !fbPrev_ff;
  assign fbLags  = sinceRef_ff < {1'b0, refPeriod_ff[11:1]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refPrev_ff    <= 1'b0;
      fbPrev_ff     <= 1'b0;
      refSelPrev_ff <= 1'b0;
    end else begin
      refPrev_ff    <= refPick;
      fbPrev_ff     <= fbIn;
      refSelPrev_ff <= ref_source_select;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sinceRef_ff  <= 12'h000;
      refPeriod_ff <= 12'h000;
    end else if (refRise) begin
      sinceRef_ff  <= 12'h000;
      refPeriod_ff <= sinceRef_ff + 12'h001;
    end else if (sinceRef_ff != 12'hfff) begin
      sinceRef_ff  <= sinceRef_ff + 12'h001;
    end
  end

  // a skewed feedback output is what gets aligned, so all others shift the other way
  always_comb begin
    nxt_step = STEP_RUN;
    if (fbRise && !refRise) begin
      if (fbLags && loopState_ff == LOOP_TRACK) begin
        nxt_step = STEP_ADV;
      end else begin
        nxt_step = STEP_HOLD;
      end
    end
  end

  always_comb begin
    nxt_loopState = loopState_ff;
    unique case (loopState_ff)
      LOOP_TRACK: begin
        if (ref_source_select != refSelPrev_ff) begin
          nxt_loopState = LOOP_REACQ;
        end
      end
      LOOP_REACQ: begin
        if (fbRise && refRise) begin
          nxt_loopState = LOOP_TRACK;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_ff <= STEP_RUN;
    end else begin
      step_ff <= nxt_step;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loopState_ff <= LOOP_TRACK;
    end else begin
      loopState_ff <= nxt_loopState;
    end
  end

  assign reacquiring = loopState_ff == LOOP_REACQ;

  // outputs 0-3 bank one, 4-9 bank two, 10 feedback
  mpcd_chan_if chanIf [NUM_OUT] ();

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    assign chanIf[i].period = (i < 4) ? pB1 : ((i < 10) ? pB2 : pFb);
    assign chanIf[i].reload = mpcd_reload(chanIf[i].period,
      (i < 2) ? skewA : ((i < 4) ? skewB : ((i < 10) ? skew2 : fbSkew)));
    assign chanIf[i].step   = step_ff;
    assign chanIf[i].wrap   = frameWrap;
    assign chanIf[i].excess = frameExcess;
    assign chanClk[i]       = chanIf[i].clkOut;
    mpcd_channel u_chan (
      .clk     (clk),
      .sys_rst (sys_rst),
      .port    (chanIf[i])
    );
  end

  assign bank1Outputs     = chanClk[3:0];
  assign bank2Outputs     = chanClk[9:4];
  assign feedbackClockOut = chanClk[10];

  pin_ref_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##2 1'b1 |-> ref_source_select == $past(refSourceSelect, 2))
    else $error("reference select not taken two cycles after the pin");

  range_n_a: assert property (@(posedge clk) disable iff (sys_rst)
    (rangeSel == TRI_LOW && nFactor == N_LOW) || (rangeSel == TRI_HIGH && nFactor == N_HIGH)
    || ((rangeSel == TRI_MID || rangeSel == TRI_OPEN) && nFactor == N_MID))
    else $error("range factor does not match the range select");

  open_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fbPh == TRI_OPEN) |-> fbSkew == SKEW_ZERO)
    else $error("open feedback phase select not read as mid");

  bank1_skew_a: assert property (@(posedge clk) disable iff (sys_rst)
    skewB >= -B1_SKEW_BIAS && skewB <= B1_SKEW_BIAS
    && ((idxB == SEL_CENTER) == (skewB == SKEW_ZERO)) && ((idxB == SEL_LAST) == (skewB == 5'sh04)))
    else $error("bank one skew outside its table");

  bank2_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    (idx2 == B2_FOLLOW_A |-> skew2 == skewA) and (idx2 == B2_FOLLOW_B |-> skew2 == skewB)
    and (idx2 == 4'h0 |-> skew2 == -B2_SKEW_BIAS) and (idx2 == SEL_LAST |-> skew2 == 5'sh08))
    else $error("bank two skew does not follow its table");

  fb_skew_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    fbSkew == -FB_SKEW_STEP || fbSkew == SKEW_ZERO || fbSkew == FB_SKEW_STEP)
    else $error("feedback skew takes a value outside the set");

  div_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    (b1DivIdx == SEL_LAST |-> pB1 == {6'h00, nFactor} * 12'h00c)
    and (b1DivIdx == 4'h6 |-> pB1 == {6'h00, nFactor} * 12'h008))
    else $error("bank one divide ratio wrong");

  bank_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    chanIf[0].period == pB1 && chanIf[3].period == pB1 && chanIf[4].period == pB2
    && chanIf[9].period == pB2 && chanIf[10].period == pFb)
    else $error("an output uses another bank's divider");

  reacq_no_adv_a: assert property (@(posedge clk) disable iff (sys_rst)
    loopState_ff == LOOP_REACQ |=> step_ff != STEP_ADV)
    else $error("loop shortened a period while reacquiring");

  switch_reacq_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_source_select != refSelPrev_ff && loopState_ff == LOOP_TRACK) |=> loopState_ff == LOOP_REACQ)
    else $error("reference switch did not start reacquisition");

  lag_advance_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fbRise && !refRise && fbLags && loopState_ff == LOOP_TRACK) |=> step_ff == STEP_ADV
    ##1 step_ff != STEP_ADV)
    else $error("late feedback edge did not advance the phase once");

  lead_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (fbRise && !refRise && !fbLags) |=> step_ff == STEP_HOLD ##1 $stable(frame_ff))
    else $error("early feedback edge did not retard the phase");

endmodule : mpcd_top

// >>> inc/mpcd_pkg.sv
// Purpose: shared constants, types and decode helpers of the clock divider
// Assumes: each three-level pin arrives as a 2-bit code, 2'h3 meaning open
// Notes:   one time unit equals one clk period
package mpcd_pkg;

  localparam int                CNT_W         = 12;
  localparam logic [1:0]        TRI_LOW       = 2'h0;
  localparam logic [1:0]        TRI_MID       = 2'h1;
  localparam logic [1:0]        TRI_HIGH      = 2'h2;
  localparam logic [1:0]        TRI_OPEN      = 2'h3;
  localparam logic [5:0]        N_LOW         = 6'h20;
  localparam logic [5:0]        N_MID         = 6'h10;
  localparam logic [5:0]        N_HIGH        = 6'h08;
  // lcm of all divide ratios, so every divided output repeats in one frame
  localparam logic [6:0]        FRAME_PERIODS = 7'h78;
  localparam logic [3:0]        DIV_TABLE [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                                  4'h6, 4'h8, 4'ha, 4'hc};
  localparam logic signed [4:0] B1_SKEW_BIAS  = 5'sh04;
  localparam logic signed [4:0] B2_SKEW_BIAS  = 5'sh08;
  localparam logic signed [4:0] FB_SKEW_STEP  = 5'sh04;
  localparam logic signed [4:0] SKEW_ZERO     = 5'sh00;
  localparam logic [3:0]        B2_LOW_LAST   = 4'h2;
  localparam logic [3:0]        B2_FOLLOW_A   = 4'h3;
  localparam logic [3:0]        SEL_CENTER    = 4'h4;
  localparam logic [3:0]        B2_FOLLOW_B   = 4'h5;
  localparam logic [3:0]        SEL_LAST      = 4'h8;
  localparam logic [1:0]        STEP_HOLD     = 2'h0;
  localparam logic [1:0]        STEP_RUN      = 2'h1;
  localparam logic [1:0]        STEP_ADV      = 2'h2;
  localparam logic [31:0]       PIN_RESET     = 32'h0000_0000;

  typedef enum logic [0:0] {
    LOOP_TRACK = 1'b0,
    LOOP_REACQ = 1'b1
  } mpcd_loop_type;

  function automatic logic [1:0] mpcd_tri_level(input logic [1:0] code);
    mpcd_tri_level = (code == TRI_OPEN) ? TRI_MID : code;
  endfunction : mpcd_tri_level

  function automatic logic [3:0] mpcd_sel_index(input logic [1:0] hi, input logic [1:0] lo);
    logic [1:0] h;
    logic [1:0] l;
    h = mpcd_tri_level(hi);
    l = mpcd_tri_level(lo);
    mpcd_sel_index = {1'b0, h, 1'b0} + {2'b00, h} + {2'b00, l};
  endfunction : mpcd_sel_index

  function automatic logic [11:0] mpcd_period(input logic [5:0] n, input logic [3:0] d);
    mpcd_period = {6'h00, n} * {8'h00, d};
  endfunction : mpcd_period

  function automatic logic [11:0] mpcd_reload(input logic [11:0] p, input logic signed [4:0] s);
    logic [4:0] mag;
    mag = s[4] ? 5'(-s) : 5'(s);
    if (s[4] || mag == 5'h00) begin
      mpcd_reload = {7'h00, mag};
    end else begin
      mpcd_reload = p - {7'h00, mag};
    end
  endfunction : mpcd_reload

endpackage : mpcd_pkg

// >>> inc/mpcd_chan_if.sv
// Purpose: setup and timing strobes from the phase generator to one output
// Assumes: all members live on clk
// Notes:   step and wrap are shared by every output of the device
`timescale 1ns/10ps
interface mpcd_chan_if;
  logic [11:0] period;
  logic [11:0] reload;
  logic [1:0]  step;
  logic        wrap;
  logic        excess;
  logic        clkOut;
  modport cfg  (output period, reload, step, wrap, excess, input clkOut);
  modport chan (input period, reload, step, wrap, excess, output clkOut);
endinterface : mpcd_chan_if

// >>> logic/mpcd_channel.sv
// Purpose: one divided and skewed clock output
// Assumes: period is at least 8 and reload below period plus 1
// Notes:   phase restarts from reload at every frame wrap
`timescale 1ns/10ps
module mpcd_channel
  import mpcd_pkg::*;
(
  input wire logic   clk,
  input wire logic   sys_rst,
  mpcd_chan_if.chan  port
);

  logic [11:0] phase_ff;
  logic [11:0] nxt_phase;
  logic [12:0] sum;
  logic        clkOut_ff;

  always_comb begin
    sum = {1'b0, phase_ff} + {11'h000, port.step};
    if (port.wrap) begin
      sum = {1'b0, port.reload} + {12'h000, port.excess};
    end
    // a setup change may leave the phase out of range; restart, a glitch is accepted
    if (phase_ff >= port.period && !port.wrap) begin
      nxt_phase = 12'h000;
    end else if (sum >= {1'b0, port.period}) begin
      nxt_phase = 12'(sum - {1'b0, port.period});
    end else begin
      nxt_phase = sum[11:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_ff <= 12'h000;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // high for the first half of each period, so the rising edge marks phase 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkOut_ff <= 1'b0;
    end else begin
      clkOut_ff <= nxt_phase < {1'b0, port.period[11:1]};
    end
  end

  assign port.clkOut = clkOut_ff;

  phase_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!port.wrap && port.step == STEP_RUN && $stable(port.period)
      && {1'b0, phase_ff} + 13'h0001 < {1'b0, port.period})
    |=> phase_ff == $past(phase_ff) + 12'h001)
    else $error("output phase did not advance by one unit");

  phase_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($stable(port.period) && phase_ff < port.period) |=> phase_ff < $past(port.period))
    else $error("output phase left its period");

endmodule : mpcd_channel

// >>> tb/mpcd_board_model.sv
// Purpose: board side of the clock buffer, references and feedback trace
// Assumes: references change just after rising clk edges
// Notes:   one shared period; secondary leads primary by secLag cycles
`timescale 1ns/10ps
module mpcd_board_model (
  input  wire logic [15:0] refPeriod,
  input  wire logic [15:0] secLag,
  input  wire logic        clk,
  input  wire logic        feedbackClockOut,
  output logic             primaryReference,
  output logic             secondaryReference,
  output wire logic        feedbackInput
);
  logic [15:0] phaseCnt;
  initial begin
    phaseCnt = 16'h0000;
    primaryReference = 1'b0;
    secondaryReference = 1'b0;
  end
  // reference rate follows the range strap the bench chose
  always @(posedge clk) begin
    phaseCnt <= (phaseCnt + 16'h0001 >= refPeriod) ? 16'h0000 : phaseCnt + 16'h0001;
    primaryReference <= phaseCnt < (refPeriod >> 1);
    secondaryReference <= ((phaseCnt + secLag) % refPeriod) < (refPeriod >> 1);
  end
  // feedback output wired straight back
  assign feedbackInput = feedbackClockOut;
endmodule : mpcd_board_model

// >>> tb/tb_multiphase_clock_divider_skew.sv
// Purpose: self-checking bench of the multiphase clock divider
// Assumes: outputs sampled at falling edges, inputs driven there too
// Notes:   offsets only checked when all banks share one divide ratio
`timescale 1ns/10ps
module tb_multiphase_clock_divider_skew;
  logic        clk, sysRst, refSourceSelect, reacquiring, feedbackClockOut;
  logic        primaryReference, secondaryReference;
  wire logic   feedbackInput;
  logic [1:0]  freqRangeSelect, feedbackPhaseSelect;
  logic [7:0]  bank1PhaseSelect;
  logic [3:0]  bank2PhaseSelect, bank1DivideSelect, bank2DivideSelect, feedbackDivideSelect;
  logic [3:0]  bank1Outputs;
  logic [5:0]  bank2Outputs;
  logic [15:0] refPeriod, secLag;
  logic [31:0] seed;
  int          mismatches, nCompared;
  wire  [10:0] allOuts = {feedbackClockOut, bank2Outputs, bank1Outputs};

  mpcd_top dut_u (.clk(clk), .sys_rst(sysRst), .freqRangeSelect(freqRangeSelect),
    .refSourceSelect(refSourceSelect), .primaryReference(primaryReference),
    .secondaryReference(secondaryReference), .feedbackInput(feedbackInput),
    .bank1PhaseSelect(bank1PhaseSelect), .bank2PhaseSelect(bank2PhaseSelect),
    .feedbackPhaseSelect(feedbackPhaseSelect), .bank1DivideSelect(bank1DivideSelect),
    .bank2DivideSelect(bank2DivideSelect), .feedbackDivideSelect(feedbackDivideSelect),
    .bank1Outputs(bank1Outputs), .bank2Outputs(bank2Outputs),
    .feedbackClockOut(feedbackClockOut), .reacquiring(reacquiring));
  mpcd_board_model board_u (.clk(clk), .refPeriod(refPeriod), .secLag(secLag),
    .feedbackClockOut(feedbackClockOut), .primaryReference(primaryReference),
    .secondaryReference(secondaryReference), .feedbackInput(feedbackInput));

  always #5 clk = ~clk;

  function automatic int nextRand(input int m);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % 32'(m));
  endfunction : nextRand
  // open pin reads as mid
  function automatic int lvl(input logic [1:0] c);
    return (c == 2'h3) ? 1 : int'(c);
  endfunction : lvl
  function automatic logic [1:0] enc(input int v);
    return (v == 1 && nextRand(2) == 1) ? 2'h3 : 2'(v);
  endfunction : enc
  function automatic int idxOf(input logic [3:0] s);
    return 3 * lvl(s[3:2]) + lvl(s[1:0]);
  endfunction : idxOf
  function automatic int divOf(input int i);
    int t[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
    return t[i];
  endfunction : divOf
  function automatic int nOf();
    return (lvl(freqRangeSelect) == 0) ? 32 : (lvl(freqRangeSelect) == 1) ? 16 : 8;
  endfunction : nOf
  function automatic int periodOf(input int j);
    return nOf() * divOf(idxOf(j < 4 ? bank1DivideSelect : j < 10 ? bank2DivideSelect
                                     : feedbackDivideSelect));
  endfunction : periodOf
  function automatic int skewOf(input int j);
    int sA, sB, i2;
    sA = idxOf(bank1PhaseSelect[3:0]) - 4;
    sB = idxOf(bank1PhaseSelect[7:4]) - 4;
    i2 = idxOf(bank2PhaseSelect);
    if (j < 2) return sA;
    if (j < 4) return sB;
    if (j == 10) return 4 * lvl(feedbackPhaseSelect) - 4;
    if (i2 == 3) return sA;
    if (i2 == 5) return sB;
    return (i2 < 3) ? i2 - 8 : (i2 == 4) ? 0 : i2;
  endfunction : skewOf

  task automatic cmpCount(input string what, input int exp, input int got);
    nCompared++;
    if (exp != got) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmpCount
  task automatic cmpFlag(input string what, input logic exp, input logic got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmpFlag

  task automatic configure(input int eq);
    int rg, mx, d[3];
    rg = nextRand(4);
    mx = (rg == 2) ? 9 : 2; // long periods only on the fast range, to keep lock short
    for (int k = 0; k < 3; k++) d[k] = (eq && k > 0) ? d[0] : nextRand(mx);
    freqRangeSelect = 2'(rg);
    bank1DivideSelect = {enc(d[0] / 3), enc(d[0] % 3)};
    bank2DivideSelect = {enc(d[1] / 3), enc(d[1] % 3)};
    feedbackDivideSelect = {enc(d[2] / 3), enc(d[2] % 3)};
    bank1PhaseSelect = 8'(nextRand(256));
    bank2PhaseSelect = 4'(nextRand(16));
    feedbackPhaseSelect = 2'(nextRand(4));
    refPeriod = 16'(periodOf(10));
  endtask : configure

  task automatic waitLock(input int chk);
    int aligned, lastFb, c;
    logic pr, pf, r, f;
    // new phase straps reach the output phases only at a frame wrap, holds included
    if (!chk) repeat (136 * nOf()) @(negedge clk);
    aligned = 0;
    lastFb = -1;
    pr = 1'b1;
    pf = 1'b1;
    for (c = 0; c < int'(refPeriod) * int'(refPeriod) + 2000 && aligned < 3; c++) begin
      @(negedge clk);
      r = refSourceSelect ? secondaryReference : primaryReference;
      f = feedbackClockOut;
      if (f && !pf) begin
        if (chk && lastFb >= 0 && reacquiring === 1'b1)
          cmpFlag("period not short", 1'b1, c - lastFb >= int'(refPeriod));
        aligned = (r && !pr) ? aligned + 1 : 0;
        lastFb = c;
      end
      pr = r;
      pf = f;
    end
    cmpFlag("feedback aligned", 1'b1, aligned == 3);
  endtask : waitLock

  task automatic measure(input int j, output int off, output int hi, output int per);
    int c, st, base;
    logic pf, po;
    off = -1;
    hi = -1;
    per = -1;
    st = 0;
    base = 0;
    pf = 1'b1;
    po = allOuts[j];
    for (c = 0; c < 8 * int'(refPeriod) + 400 && per < 0; c++) begin
      @(negedge clk);
      if (st == 0 && feedbackClockOut && !pf) st = 1;
      if (st == 1) base = (off < 0 && base == 0) ? c : base;
      if (allOuts[j] && !po && st == 1) begin off = c - base; st = 2; base = c; end
      else if (allOuts[j] && !po && st == 3) per = c - base;
      else if (!allOuts[j] && po && st == 2) begin hi = c - base; st = 3; end
      pf = feedbackClockOut;
      po = allOuts[j];
    end
  endtask : measure

  task tally_and_finish;
    if (mismatches == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #1_000_000;
    mismatches++;
    $display("[FAIL] run length expected done seen timeout");
    tally_and_finish;
  end

  initial begin
    int off, hi, per, pj;
    {clk, refSourceSelect, freqRangeSelect, feedbackPhaseSelect} = '0;
    {bank1PhaseSelect, bank2PhaseSelect, bank1DivideSelect} = '0;
    {bank2DivideSelect, feedbackDivideSelect} = '0;
    sysRst = 1'b1;
    refPeriod = 16'h0020;
    secLag = 16'h0005;
    seed = 32'h88e9;
    mismatches = 0;
    nCompared = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    sysRst = 1'b0;
    for (int it = 0; it < 6; it++) begin
      @(negedge clk);
      configure(it % 2 == 0);
      waitLock(0);
      cmpFlag("reacquiring idle", 1'b0, reacquiring);
      for (int j = 0; j < 11; j++) begin
        measure(j, off, hi, per);
        pj = periodOf(j);
        cmpCount("output period", pj, per);
        cmpCount("output high time", pj / 2, hi);
        if (it % 2 == 0)
          cmpCount("offset to feedback", ((skewOf(j) - skewOf(10)) % pj + pj) % pj, off);
      end
    end
    @(negedge clk);
    freqRangeSelect = 2'h2;
    {bank1DivideSelect, bank2DivideSelect, feedbackDivideSelect} = {3{4'h1}};
    {bank1PhaseSelect, bank2PhaseSelect, feedbackPhaseSelect} = {7{2'h1}};
    refPeriod = 16'h0010;
    waitLock(0);
    for (int s = 1; s >= 0; s--) begin
      @(negedge clk);
      refSourceSelect = s[0];
      for (int c = 0; c < 6 && reacquiring !== 1'b1; c++) @(negedge clk);
      cmpFlag("reacquire entered", 1'b1, reacquiring);
      waitLock(1);
      repeat (2) @(negedge clk);
      cmpFlag("reacquire left", 1'b0, reacquiring);
    end
    tally_and_finish;
  end
endmodule : tb_multiphase_clock_divider_skew
